// File: rtl/adc_pkg.sv
package adc_pkg;
  // register byte addresses
  localparam logic [7:0] REG_STATUS_CONTROL = 8'h1e;
  localparam logic [7:0] REG_RESULT         = 8'h1f;
  // status/control field positions
  localparam int BIT_CONV_DONE  = 7;
  localparam int BIT_RC_SELECT  = 6;
  localparam int BIT_POWER_ON   = 5;
  localparam int CH_LSB         = 0;
  localparam int CH_WIDTH       = 2;
  // reset values
  localparam logic [7:0] STATUS_CONTROL_RESET = 8'h00;
  localparam logic [7:0] RESULT_RESET         = 8'h00;
  // data width and sar timing in converter clock ticks
  localparam int          DATA_W       = 8;
  localparam logic [4:0]  CONV_LAST    = 5'h1f;   // 32 ticks, counted 0..31
  localparam logic [4:0]  SAMPLE_LAST  = 5'h16;   // ticks 0..22 sample
  localparam logic [7:0]  DAC_MSB      = 8'h80;
  // port c pin of channel 0; channel n sits at this minus n
  localparam logic [2:0]  PORTC_CH0_BIT = 3'h6;
  // clock figures
  localparam int CLK_KHZ          = 20000;
  localparam int RC_OSC_NOM_KHZ   = 1500;
  localparam int RC_NEEDED_BELOW_KHZ = 1000;
  // settle times in microseconds (plain defaults) and derived cycle counts
  localparam int RC_OSC_SETTLE_TIME_US    = 1;
  localparam int CONVERTER_SETTLE_TIME_US = 1;
  localparam int RC_OSC_SETTLE_CYCLES     = (RC_OSC_SETTLE_TIME_US * CLK_KHZ + 999) / 1000;
  localparam int CONVERTER_SETTLE_CYCLES  = (CONVERTER_SETTLE_TIME_US * CLK_KHZ + 999) / 1000;
  // sar engine states
  typedef enum logic [1:0] {
    SAR_IDLE   = 2'b00,
    SAR_SAMPLE = 2'b01,
    SAR_DECIDE = 2'b10,
    SAR_FINISH = 2'b11
  } sar_state_t;
endpackage

// File: rtl/sar_if.sv
`timescale 1ns/1ps
// control and data between register front end and sar engine
interface sar_if;
  logic       start;      // begin a fresh conversion (restarts a running one)
  logic       abort;      // stop mode or power off
  logic       tick;       // converter clock enable
  logic       cmp_above;  // sampled input at or above dac output
  logic [7:0] dac_code;   // trial code to the dac
  logic       busy;       // conversion running or pending
  logic       done;       // one-cycle completion pulse
  logic [7:0] result;     // code of the finished conversion
  modport ctrl   (output start, abort, tick, cmp_above, input dac_code, busy, done, result);
  modport engine (input start, abort, tick, cmp_above, output dac_code, busy, done, result);
endinterface

// File: rtl/sar_engine.sv
`timescale 1ns/1ps
module sar_engine
  import adc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link to the front end
  sar_if.engine    s
);
  sar_state_t state;          // engine state
  logic [4:0] tick_cnt;       // converter ticks into this conversion
  logic [2:0] bit_idx;        // bit under trial
  logic       pending;        // start seen, waiting for a tick

  // busy covers both pending and running; only the checks use it, software never sees it
  assign s.busy = pending | (state != SAR_IDLE);

  // sequencing: abort beats start, start beats running
  always_ff @(posedge clk) begin
    if (rst || s.abort) begin
      state    <= SAR_IDLE;
      tick_cnt <= 5'h00;
      bit_idx  <= 3'h7;
      pending  <= 1'b0;
      s.done   <= 1'b0;
      s.dac_code <= 8'h00;
      s.result <= RESULT_RESET;
    end else begin
      s.done <= 1'b0;
      if (s.start && !s.tick) begin
        pending <= 1'b1;      // rc tick not yet here
        state   <= SAR_IDLE;
      end else if ((s.start || pending) && s.tick) begin
        pending  <= 1'b0;
        state    <= SAR_SAMPLE;
        tick_cnt <= 5'h00;
      end else if (s.tick) begin
        case (state)
          SAR_IDLE: begin
            tick_cnt <= 5'h00;
          end
          SAR_SAMPLE: begin
            tick_cnt <= tick_cnt + 5'h01;
            if (tick_cnt == SAMPLE_LAST) begin
              state      <= SAR_DECIDE;
              bit_idx    <= 3'h7;
              s.dac_code <= DAC_MSB;   // msb tried first
            end
          end
          SAR_DECIDE: begin
            tick_cnt <= tick_cnt + 5'h01;
            // keep the bit only if the input is not below it
            if (!s.cmp_above) s.dac_code[bit_idx] <= 1'b0;
            if (bit_idx != 3'h0) begin
              s.dac_code[bit_idx - 3'h1] <= 1'b1;
              bit_idx <= bit_idx - 3'h1;
            end else begin
              state <= SAR_FINISH;
            end
          end
          SAR_FINISH: begin
            // full-scale input keeps every bit, giving ff
            if (tick_cnt == CONV_LAST) begin
              s.result <= s.dac_code;
              s.done   <= 1'b1;
              state    <= SAR_IDLE;
            end else begin
              tick_cnt <= tick_cnt + 5'h01;
            end
          end
          default: state <= SAR_IDLE;
        endcase
      end
    end
  end

  // helper: cycles since a conversion began while every cycle ticked
  logic [5:0] run_cycles;
  logic       all_fast;
  always_ff @(posedge clk) begin
    if (rst || s.abort || s.start) begin
      run_cycles <= 6'h00;
      all_fast   <= s.tick;
    end else begin
      if (run_cycles != 6'h3f) run_cycles <= run_cycles + 6'h01;
      if (!s.tick) all_fast <= 1'b0;
    end
  end

  sequence s_enter_decide;
    (state == SAR_SAMPLE) && s.tick && (tick_cnt == SAMPLE_LAST) && !s.start && !pending;
  endsequence
  property p_msb_first;
    @(posedge clk) disable iff (rst) s_enter_decide ##1 !s.abort |-> s.dac_code == DAC_MSB;
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first trial code is not msb");

  property p_conv_length;
    @(posedge clk) disable iff (rst) s.done && all_fast |-> run_cycles == 6'h20;
  endproperty
  a_conv_length: assert property (p_conv_length) else $error("conversion not 32 cycles");

  property p_abort_idle;
    @(posedge clk) disable iff (rst) s.abort |=> !s.busy && !s.done;
  endproperty
  a_abort_idle: assert property (p_abort_idle) else $error("abort left engine busy");
endmodule // sar_engine

// File: rtl/adc_control.sv
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module adc_control
  import adc_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // converter clocking and power modes
  input  wire logic       rc_osc_tick,
  input  wire logic       stop_mode,
  // analog side
  input  wire logic       cmp_above,
  output logic      [7:0] dac_code,
  output logic      [3:0] analog_mux_sel,
  output logic            comparator_enable,
  // port c digital path
  input  wire logic [7:0] port_c_pins,
  output logic      [7:0] port_c_read
);
  sar_if s ();

  // control bits held by software
  logic                conv_done_flag;     // hardware set, access clears
  logic                rc_clock_select;    // converter clock source
  logic                converter_power_on; // converter enable
  logic [CH_WIDTH-1:0] channel_select;     // analog channel
  logic [7:0]          adc_result;         // last finished code

  // decoded accesses
  logic hit_status;  // strobe aimed at status/control
  logic hit_result;  // strobe aimed at the result
  logic access;      // any access of either register
  logic running;     // converter allowed to operate

  assign hit_status = (rd || wr) && (addr == REG_STATUS_CONTROL);
  assign hit_result = (rd || wr) && (addr == REG_RESULT);
  assign access     = hit_status || hit_result;
  // wait mode is deliberately not an input: the converter ignores it
  // leaving stop resumes at once; clock start-up already covers settling
  assign running    = converter_power_on && !stop_mode;

  // drive the engine link
  // rc ticks arrive already in the internal clock domain, so the hand-over of the
  // result is an ordinary clocked load; throughput is bounded by that clock
  assign s.tick      = rc_clock_select ? rc_osc_tick : 1'b1;
  assign s.abort     = !running;
  // an access restarts; a completion re-arms the next conversion
  assign s.start     = running && (access || s.done);
  assign s.cmp_above = cmp_above;

  sar_engine u_sar (
    .clk (clk),
    .rst (rst),
    .s   (s)
  );

  // control bits: written as a whole byte, flag bit ignored on write
  always_ff @(posedge clk) begin
    if (rst) begin
      rc_clock_select    <= STATUS_CONTROL_RESET[BIT_RC_SELECT];
      converter_power_on <= STATUS_CONTROL_RESET[BIT_POWER_ON];
      channel_select     <= STATUS_CONTROL_RESET[CH_LSB +: CH_WIDTH];
    end else if (wr && addr == REG_STATUS_CONTROL) begin
      rc_clock_select    <= wdata[BIT_RC_SELECT];
      converter_power_on <= wdata[BIT_POWER_ON];
      channel_select     <= wdata[CH_LSB +: CH_WIDTH];
    end
  end

  // completion flag: a completion in the access cycle wins over the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      conv_done_flag <= STATUS_CONTROL_RESET[BIT_CONV_DONE];
    end else if (s.done) begin
      conv_done_flag <= 1'b1;
    end else if (access || s.start || !running) begin
      conv_done_flag <= 1'b0;
    end
  end

  // result: each completion overwrites, read or not
  always_ff @(posedge clk) begin
    if (rst) begin
      adc_result <= RESULT_RESET;
    end else if (s.done) begin
      adc_result <= s.result;
    end
  end

  // read data, valid only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd && addr == REG_STATUS_CONTROL) begin
      // bits 4..2 are absent and read as zero
      rdata <= {conv_done_flag, rc_clock_select, converter_power_on, 3'h0, channel_select};
    end else if (rd && addr == REG_RESULT) begin
      rdata <= adc_result;                          // writes here are ignored
    end else begin
      rdata <= 8'h00;                               // idle or unmapped
    end
  end

  // analog side outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      analog_mux_sel    <= 4'h0;
      comparator_enable <= 1'b0;
    end else begin
      analog_mux_sel    <= 4'h1 << channel_select;
      comparator_enable <= running;
    end
  end

  // trial code leaves straight from the engine's register: a copy one clock
  // later would let the comparator judge the previous code at full cpu rate
  assign dac_code = s.dac_code;

  // port c digital reads: with the converter on, the selected analog pin reads zero, others pass
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_portc
      logic is_analog;  // this pin currently feeds the multiplexer
      assign is_analog = converter_power_on &&
                         (3'(gi) == PORTC_CH0_BIT - 3'(channel_select));
      always_ff @(posedge clk) begin
        if (rst) begin
          port_c_read[gi] <= 1'b0;
        end else begin
          port_c_read[gi] <= port_c_pins[gi] && !is_analog;
        end
      end
    end
  endgenerate

  // ---- checks ----
  sequence s_status_read;
    rd && (addr == REG_STATUS_CONTROL);
  endsequence

  property p_reserved_zero;
    @(posedge clk) disable iff (rst) s_status_read |=> rdata[4:2] == 3'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

  property p_flag_set;
    @(posedge clk) disable iff (rst) s.done |=> conv_done_flag && (adc_result == $past(s.result));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag or result missed completion");

  property p_access_clears;
    @(posedge clk) disable iff (rst) access && !s.done |=> !conv_done_flag;
  endproperty
  a_access_clears: assert property (p_access_clears) else $error("access left flag set");

  property p_access_starts;
    @(posedge clk) disable iff (rst) access && running && !stop_mode ##1 running |-> s.busy;
  endproperty
  a_access_starts: assert property (p_access_starts) else $error("access did not start");

  property p_result_stable;
    @(posedge clk) disable iff (rst) !s.done |=> $stable(adc_result);
  endproperty
  a_result_stable: assert property (p_result_stable) else $error("result moved without done");

  property p_power_off;
    @(posedge clk) disable iff (rst) !converter_power_on |=> !s.busy && !comparator_enable;
  endproperty
  a_power_off: assert property (p_power_off) else $error("converter ran while off");

  property p_mux_route;
    @(posedge clk) disable iff (rst) 1'b1 |=> analog_mux_sel == (4'h1 << $past(channel_select));
  endproperty
  a_mux_route: assert property (p_mux_route) else $error("mux select wrong");

  property p_pin_masked;
    @(posedge clk) disable iff (rst)
      converter_power_on && channel_select == 2'h0 |=> port_c_read[6] == 1'b0;
  endproperty
  a_pin_masked: assert property (p_pin_masked) else $error("analog pin read nonzero");

  property p_other_pins;
    @(posedge clk) disable iff (rst)
      channel_select == 2'h3 |=> port_c_read[6] == $past(port_c_pins[6]);
  endproperty
  a_other_pins: assert property (p_other_pins) else $error("digital pin disturbed");

  property p_stop_abort;
    @(posedge clk) disable iff (rst) stop_mode |=> !s.busy && !comparator_enable;
  endproperty
  a_stop_abort: assert property (p_stop_abort) else $error("stop did not abort");
endmodule // adc_control

// File: tb/analog_model.sv
`timescale 1ns/1ps
// far side: input pin level against the dac trial code
module analog_model (
  // clock for the idle pattern
  input  wire logic       clk,
  // analog side of the converter
  input  wire logic [7:0] dac_code,
  input  wire logic       comparator_enable,
  input  wire logic [7:0] analog_level,
  output logic            cmp_above
);
  logic idle_toggle = 1'b0;  // garbage while the comparator is off

  // a disabled comparator gives no stable answer, so never hand back a constant
  always @(posedge clk) begin
    idle_toggle <= ~idle_toggle;
  end

  // at or above the trial code; full scale always above
  assign cmp_above = comparator_enable ? (analog_level >= dac_code) : idle_toggle;
endmodule // analog_model

// File: tb/test_sar_adc_control.sv
`timescale 1ns/1ps
// register level tests of the converter control block
module test_sar_adc_control;
  import adc_pkg::*;
  logic       clk          = 1'b0;   // 20 mhz
  logic       rst          = 1'b1;   // sync, active high
  logic       wr           = 1'b0;   // write strobe
  logic       rd           = 1'b0;   // read strobe
  logic       rc_osc_tick  = 1'b0;   // rc converter clock pulse
  logic       stop_mode    = 1'b0;   // stop level
  logic [7:0] addr         = 8'h00;  // register address
  logic [7:0] wdata        = 8'h00;  // write data
  logic [7:0] port_c_pins  = 8'hff;  // digital pin levels
  logic [7:0] analog_level = 8'h5a;  // pin voltage as a code
  wire  logic cmp_above;             // comparator answer
  wire  logic comparator_enable;     // comparator power
  wire  logic [7:0] rdata;           // read data
  wire  logic [7:0] dac_code;        // trial code
  wire  logic [7:0] port_c_read;     // digital port view
  wire  logic [3:0] analog_mux_sel;  // one-hot channel
  int         mismatches   = 0;      // failed compares
  int         compares     = 0;      // all compares
  int         tick_div     = 0;      // rc tick divider
  logic [7:0] got          = 8'h00;  // last polled status
  int         polls        = 0;      // status polls so far

  // clock
  always #25 clk = ~clk;

  // rc tick every 13 clocks, near 1.5 mhz, so a conversion is some 416 clocks
  always @(posedge clk) begin
    tick_div    <= (tick_div == 12) ? 0 : tick_div + 1;
    rc_osc_tick <= (tick_div == 12);
  end

  // block under test
  adc_control DUT (
    .clk               (clk),
    .rst               (rst),
    .addr              (addr),
    .wdata             (wdata),
    .wr                (wr),
    .rd                (rd),
    .rdata             (rdata),
    .rc_osc_tick       (rc_osc_tick),
    .stop_mode         (stop_mode),
    .cmp_above         (cmp_above),
    .dac_code          (dac_code),
    .analog_mux_sel    (analog_mux_sel),
    .comparator_enable (comparator_enable),
    .port_c_pins       (port_c_pins),
    .port_c_read       (port_c_read)
  );

  // far side: pin level against the trial code
  analog_model u_model (
    .clk               (clk),
    .dac_code          (dac_code),
    .comparator_enable (comparator_enable),
    .analog_level      (analog_level),
    .cmp_above         (cmp_above)
  );

  // verdict, reached by the tests and by the watchdog alike
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if ((mismatches == 0) && (compares > 0)) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // byte compare; x or z never passes
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    compares = compares + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // wait n rising edges; caller resumes just after the last one
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one-cycle write strobe
  task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // one-cycle read strobe; data stands only in the next cycle, taken mid-cycle
  task automatic bus_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  // read and compare; note every read while the converter runs also restarts a conversion
  task automatic read_check(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    bus_read(a, d);
    check(what, exp, d);
  endtask

  // scenarios in turn
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    // reset values with the converter off
    read_check("status after reset", REG_STATUS_CONTROL, 8'h00);
    read_check("result after reset", REG_RESULT, 8'h00);
    @(negedge clk);
    check("port c while off", 8'hff, port_c_read);
    check("comparator while off", 8'h00, {7'h00, comparator_enable});
    // 20 mhz internal clock, so the rc select stays clear
    bus_write(REG_STATUS_CONTROL, 8'h20);
    read_check("status after power on", REG_STATUS_CONTROL, 8'h20);
    idle(31);
    read_check("flag one cycle early", REG_STATUS_CONTROL, 8'h20);
    read_check("flag set beats clear", REG_STATUS_CONTROL, 8'ha0);
    idle(32);
    read_check("flag after 32 cycles", REG_STATUS_CONTROL, 8'ha0);
    read_check("flag cleared by access", REG_STATUS_CONTROL, 8'h20);
    read_check("result mid scale", REG_RESULT, 8'h5a);
    @(negedge clk);
    check("port c ch0 masked", 8'hbf, port_c_read);
    check("mux ch0", 8'h01, {4'h0, analog_mux_sel});
    check("comparator on", 8'h01, {7'h00, comparator_enable});
    // unread result overwritten, then both reference ends
    idle(1);
    analog_level <= 8'h33;
    idle(40);
    analog_level <= 8'hff;
    idle(40);
    read_check("result overwritten full scale", REG_RESULT, 8'hff);
    idle(1);
    analog_level <= 8'h00;
    idle(40);
    read_check("result low reference", REG_RESULT, 8'h00);
    // channel 3, unused bits and flag written as ones
    idle(1);
    port_c_pins <= 8'h5d;
    bus_write(REG_STATUS_CONTROL, 8'hbf);
    read_check("unused bits read zero", REG_STATUS_CONTROL, 8'h23);
    @(negedge clk);
    check("mux ch3", 8'h08, {4'h0, analog_mux_sel});
    check("port c ch3 masked", 8'h55, port_c_read);
    // stop aborts with the flag set, leaving stop needs no delay
    idle(40);
    stop_mode <= 1'b1;
    idle(2);
    @(negedge clk);
    check("comparator off in stop", 8'h00, {7'h00, comparator_enable});
    read_check("stop clears flag", REG_STATUS_CONTROL, 8'h23);
    idle(40);
    read_check("no completion in stop", REG_STATUS_CONTROL, 8'h23);
    idle(1);
    stop_mode <= 1'b0;
    read_check("start after stop", REG_STATUS_CONTROL, 8'h23);
    idle(32);
    read_check("done after stop", REG_STATUS_CONTROL, 8'ha3);
    // rc converter clock: far slower, so software polls the flag
    idle(1);
    analog_level <= 8'h96;
    bus_write(REG_STATUS_CONTROL, 8'h63);
    read_check("rc mode selected", REG_STATUS_CONTROL, 8'h63);
    idle(40);
    read_check("rc conversion still busy", REG_STATUS_CONTROL, 8'h63);
    for (polls = 0; (polls < 4) && !got[7]; polls = polls + 1) begin
      idle(440);
      bus_read(REG_STATUS_CONTROL, got);
    end
    check("rc flag by polling", 8'he3, got);
    read_check("rc result", REG_RESULT, 8'h96);
    // power and rc select cleared as before wait
    bus_write(REG_STATUS_CONTROL, 8'h00);
    idle(1);
    @(negedge clk);
    check("comparator after power off", 8'h00, {7'h00, comparator_enable});
    check("dac code after power off", 8'h00, dac_code);
    check("port c all digital", 8'h5d, port_c_read);
    read_check("status while off", REG_STATUS_CONTROL, 8'h00);
    idle(40);
    read_check("no conversion while off", REG_STATUS_CONTROL, 8'h00);
    read_check("result kept while off", REG_RESULT, 8'h96);
    // second reset in mid-run
    idle(1);
    rst <= 1'b1;
    idle(16);
    rst <= 1'b0;
    read_check("status after second reset", REG_STATUS_CONTROL, 8'h00);
    read_check("result after second reset", REG_RESULT, 8'h00);
    stop_test();
  end

  // watchdog: the scenarios need some 900 cycles
  initial begin
    idle(20000);
    mismatches = mismatches + 1;
    $display("ERROR watchdog expected finish seen timeout");
    stop_test();
  end
endmodule // test_sar_adc_control
